// ### hdl/line_regs_pkg.sv
// Overview of operation
// - Two-bit mode: S line, S terminal, U, off
// - Disabled channel sends only zero bits downstream
// - Three mode registers, channel n at 2n+1:2n
// - Three write-only command registers, one per transceiver
// - Bit 0 marks command data valid
// - Bits 3:1 select reference clock channel
// - Bit 7 selects external reference clock
// - Bits 6:4 select delay measurement channel
// - Bit 8 selects 65 or 130 ns
// - Bit 9 marks next frame sync superframe
// - Bit 10 selects positive pulse sensing
// - Bit 11 requests transceiver status read
// - Unused command bits read as zero
// - Frame sync clears all command register bytes not written in the same cycle
package line_regs_pkg;
    localparam logic [15:0] IDX_MODE_LOW   = 16'hD0A1;
    localparam logic [15:0] IDX_MODE_MID   = 16'hD0A2;
    localparam logic [15:0] IDX_MODE_HIGH  = 16'hD0A3;
    localparam logic [15:0] IDX_CMD_0      = 16'hD0A8;
    localparam logic [15:0] IDX_CMD_1      = 16'hD0A9;
    localparam logic [15:0] IDX_CMD_2      = 16'hD0AA;
    localparam logic [15:0] MODE_RESET     = 16'hFFFF;
    localparam logic [15:0] CMD_RESET      = 16'h0000;
    localparam logic [15:0] CMD_USED_MASK  = 16'h0FFF;
    localparam logic [1:0]  MODE_S_LINE    = 2'h0;
    localparam logic [1:0]  MODE_S_TERM    = 2'h1;
    localparam logic [1:0]  MODE_U         = 2'h2;
    localparam logic [1:0]  MODE_OFF       = 2'h3;
    localparam int          CMD_VALID_BIT  = 0;
    localparam int          REF_SEL_LSB    = 1;
    localparam int          DELAY_CH_LSB   = 4;
    localparam int          EXT_REF_BIT    = 7;
    localparam int          DELAY_RES_BIT  = 8;
    localparam int          SUPERFRAME_BIT = 9;
    localparam int          POS_PULSE_BIT  = 10;
    localparam int          STATUS_RD_BIT  = 11;
    localparam int          CHANNELS       = 24;
    localparam int          SLOT_BITS      = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ### hdl/line_channel_mode_command_regs.sv
`timescale 1ns/1ns
module line_channel_mode_command_regs
    import line_regs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        frame_sync,
    input  wire logic [4:0]  slot_channel,
    input  wire logic        slot_data,
    output logic             downstream_data_line,
    output logic [47:0]      channel_mode_field,
    output logic [47:0]      cmd_frame
);
    logic [15:0] mode_reg [3];
    logic [15:0] cmd_reg [3];
    logic [47:0] cmd_frame_reg;
    logic        fs_meta_reg;
    logic        fs_sync_reg;
    logic        fs_prev_reg;
    logic        fs_pulse;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [15:0] aw_idx_reg;
    logic [15:0] wdata_reg;
    logic [1:0]  wstrb_reg;
    logic        wr_go;
    logic [15:0] ar_idx;
    logic [15:0] wr_idx;
    logic [15:0] wr_mask;
    logic        dl_reg;

    // Frame sync from a pin
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_meta_reg <= 1'b0;
            fs_sync_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end else begin
            fs_meta_reg <= frame_sync;
            fs_sync_reg <= fs_meta_reg;
            fs_prev_reg <= fs_sync_reg;
        end
    end
    assign fs_pulse = fs_sync_reg & ~fs_prev_reg;

    // Write channel capture
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign wr_go         = aw_held_reg & w_held_reg;
    assign wr_idx        = aw_idx_reg;
    assign wr_mask       = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_idx_reg  <= 16'h0000;
            wdata_reg   <= 16'h0000;
            wstrb_reg   <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[17:2];
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata[15:0];
                wstrb_reg  <= s_axi_wstrb[1:0];
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == IDX_MODE_LOW || wr_idx == IDX_MODE_MID ||
                             wr_idx == IDX_MODE_HIGH || wr_idx == IDX_CMD_0 ||
                             wr_idx == IDX_CMD_1 || wr_idx == IDX_CMD_2) ?
                            RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Channel mode registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg[0] <= MODE_RESET;
            mode_reg[1] <= MODE_RESET;
            mode_reg[2] <= MODE_RESET;
        end else if (wr_go) begin
            for (int r = 0; r < 3; r++) begin
                if (wr_idx == IDX_MODE_LOW + 16'(r)) begin
                    mode_reg[r] <= (mode_reg[r] & ~wr_mask) | (wdata_reg & wr_mask);
                end
            end
        end
    end
    assign channel_mode_field = {mode_reg[2], mode_reg[1], mode_reg[0]};

    // Command registers, cleared on frame sync except bytes written in that cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_reg[0] <= CMD_RESET;
            cmd_reg[1] <= CMD_RESET;
            cmd_reg[2] <= CMD_RESET;
        end else begin
            for (int r = 0; r < 3; r++) begin
                if (wr_go && wr_idx == IDX_CMD_0 + 16'(r)) begin
                    cmd_reg[r] <= ((fs_pulse ? CMD_RESET : cmd_reg[r]) & ~wr_mask) |
                                  (wdata_reg & wr_mask & CMD_USED_MASK);
                end else if (fs_pulse) begin
                    cmd_reg[r] <= CMD_RESET;
                end
            end
        end
    end

    // Frame snapshot carries bits 0..11 to each transceiver
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_frame_reg <= 48'h000000000000;
        end else if (fs_pulse) begin
            cmd_frame_reg <= {cmd_reg[2], cmd_reg[1], cmd_reg[0]};
        end
    end
    assign cmd_frame = cmd_frame_reg;

    // Downstream data, disabled channels send zeros
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dl_reg <= 1'b0;
        end else if (slot_channel >= 5'(CHANNELS)) begin
            dl_reg <= 1'b0;
        end else begin
            dl_reg <= (channel_mode_field[2*slot_channel +: 2] == MODE_OFF) ? 1'b0 : slot_data;
        end
    end
    assign downstream_data_line = dl_reg;

    // Read channel; command registers are write-only and read zero
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_idx        = s_axi_araddr[17:2];
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            if (ar_idx == IDX_MODE_LOW) begin
                s_axi_rdata <= {16'h0000, mode_reg[0]};
            end else if (ar_idx == IDX_MODE_MID) begin
                s_axi_rdata <= {16'h0000, mode_reg[1]};
            end else if (ar_idx == IDX_MODE_HIGH) begin
                s_axi_rdata <= {16'h0000, mode_reg[2]};
            end else if (ar_idx != IDX_CMD_0 && ar_idx != IDX_CMD_1 && ar_idx != IDX_CMD_2) begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_cmd_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (fs_pulse && !wr_go) |=> (cmd_reg[0] == CMD_RESET && cmd_reg[1] == CMD_RESET &&
                                  cmd_reg[2] == CMD_RESET);
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("Command not cleared");

    property p_unused_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (cmd_reg[0][15:12] == 4'h0) && (cmd_reg[1][15:12] == 4'h0) &&
        (cmd_reg[2][15:12] == 4'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("Unused bits set");

    property p_off_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (slot_channel < 5'(CHANNELS) && channel_mode_field[2*slot_channel +: 2] == MODE_OFF)
        |=> !downstream_data_line;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("Disabled channel sent one");

    property p_snapshot;
        @(posedge sys_clk) disable iff (!rst_b)
        fs_pulse |=> (cmd_frame == $past({cmd_reg[2], cmd_reg[1], cmd_reg[0]}));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("Command not sent");

    property p_resp_after_write;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_go |=> s_axi_bvalid;
    endproperty
    a_resp_after_write: assert property (p_resp_after_write) else $error("No write response");

    property p_mode_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_go && wr_idx == IDX_MODE_LOW && wr_mask == 16'hFFFF) |=>
        (mode_reg[0] == $past(wdata_reg));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("Mode not stored");

    property p_valid_bit;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_go && !fs_pulse && wr_idx == IDX_CMD_1 && wr_mask[0]) |=>
        (cmd_reg[1][CMD_VALID_BIT] == $past(wdata_reg[CMD_VALID_BIT]));
    endproperty
    a_valid_bit: assert property (p_valid_bit) else $error("Valid bit wrong");

    property p_mode_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !wr_go |=> $stable(channel_mode_field);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("Mode changed");

    // Rising edge of the synchronised frame sync
    sequence s_sync_seen;
        !fs_sync_reg ##1 fs_sync_reg;
    endsequence

    property p_sync_edge;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(fs_meta_reg) |=> fs_pulse;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("Frame sync edge lost");

    property p_ref_sel;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[16 + REF_SEL_LSB +: 3] == $past(cmd_reg[1][REF_SEL_LSB +: 3]));
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("Reference channel not sent");

    property p_ext_ref;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[32 + EXT_REF_BIT] == $past(cmd_reg[2][EXT_REF_BIT]));
    endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("External reference not sent");

    property p_delay_ch;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[DELAY_CH_LSB +: 3] == $past(cmd_reg[0][DELAY_CH_LSB +: 3]));
    endproperty
    a_delay_ch: assert property (p_delay_ch) else $error("Delay channel not sent");

    property p_delay_res;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[16 + DELAY_RES_BIT] == $past(cmd_reg[1][DELAY_RES_BIT]));
    endproperty
    a_delay_res: assert property (p_delay_res) else $error("Resolution not sent");

    property p_superframe;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[32 + SUPERFRAME_BIT] == $past(cmd_reg[2][SUPERFRAME_BIT]));
    endproperty
    a_superframe: assert property (p_superframe) else $error("Superframe not sent");

    property p_pos_pulse;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[POS_PULSE_BIT] == $past(cmd_reg[0][POS_PULSE_BIT]));
    endproperty
    a_pos_pulse: assert property (p_pos_pulse) else $error("Pulse sensing not sent");

    property p_status_rd;
        @(posedge sys_clk) disable iff (!rst_b)
        s_sync_seen |=> (cmd_frame[16 + STATUS_RD_BIT] == $past(cmd_reg[1][STATUS_RD_BIT]));
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("Status request not sent");

    property p_cmd_read_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (s_axi_arvalid && s_axi_arready &&
         (ar_idx == IDX_CMD_0 || ar_idx == IDX_CMD_1 || ar_idx == IDX_CMD_2)) |=>
        (s_axi_rvalid && s_axi_rdata == 32'h00000000 && s_axi_rresp == RESP_OKAY);
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("Command read not zero");

    property p_mode_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (s_axi_arvalid && s_axi_arready && ar_idx == IDX_MODE_MID) |=>
        (s_axi_rdata == {16'h0000, $past(mode_reg[1])});
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("Mode read wrong");

    property p_cmd_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_go && !fs_pulse && wr_idx == IDX_CMD_0 && wr_mask == 16'hFFFF) |=>
        (cmd_reg[0] == ($past(wdata_reg) & CMD_USED_MASK));
    endproperty
    a_cmd_write: assert property (p_cmd_write) else $error("Command not stored");
endmodule

// ### sim/line_xcvr_model.sv
`timescale 1ns/1ns
module line_xcvr_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       fs_go,
    output logic            frame_sync,
    output logic [4:0]      slot_channel,
    output logic            slot_data
);
    logic [7:0] cnt;
    logic [2:0] fs_cnt;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            fs_cnt <= 3'h0;
        end else begin
            cnt <= cnt + 8'h01;
            fs_cnt <= fs_go ? 3'h4 : fs_cnt - {2'h0, fs_cnt != 3'h0};
        end
    end
    assign frame_sync = fs_cnt != 3'h0;
    assign slot_channel = cnt[4:0];
    assign slot_data = cnt[5] ^ cnt[0] ^ cnt[2];
endmodule

// ### sim/line_channel_mode_command_regs_tb.sv
`timescale 1ns/1ns
module line_channel_mode_command_regs_tb;
    import line_regs_pkg::*;
    logic        sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        frame_sync, slot_data, downstream_data_line, fs_go, busy, pd;
    logic [17:0] s_axi_awaddr, s_axi_araddr, a;
    logic [31:0] s_axi_wdata, s_axi_rdata, rs, d;
    logic [31:0] c[3];
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  slot_channel, pch;
    logic [47:0] channel_mode_field, cmd_frame, mirror;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          n_fail, n_tests;

    line_channel_mode_command_regs dut (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .frame_sync, .slot_channel, .slot_data, .downstream_data_line,
        .channel_mode_field, .cmd_frame);
    line_xcvr_model xm (.sys_clk, .rst_b, .fs_go, .frame_sync, .slot_channel, .slot_data);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task chk(input logic [47:0] s, input logic [47:0] x);
        n_tests++;
        if (s !== x) begin
            n_fail++;
            $display("BAD %0t seen %h exp %h", $time, s, x);
        end
    endtask

    task end_sim;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task wr(input logic [17:0] ad, input logic [31:0] dd, input logic [1:0] r);
        int n;
        logic ha, hw, hb;
        exp_q.push_back({r, 32'h0});
        busy <= 1'b1;
        s_axi_awaddr <= ad;
        s_axi_wdata <= dd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            ha = s_axi_awready;
            hw = s_axi_wready;
            hb = s_axi_bvalid;
            @(posedge sys_clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            n++;
        end while (!hb && n < 64);
        s_axi_bready <= 1'b0;
        if (ad[17:4] == 14'h3428 && ad[3:2] != 2'h0 && r == RESP_OKAY) begin
            for (int b = 0; b < 2; b++) begin
                if (s_axi_wstrb[b]) mirror[(ad[3:2] - 2'h1) * 16 + b * 8 +: 8] = dd[b * 8 +: 8];
            end
        end
        busy <= 1'b0;
        if (!hb) begin
            n_fail++;
            end_sim();
        end
        @(posedge sys_clk);
    endtask

    task rd(input logic [17:0] ad, input logic [33:0] x);
        int n;
        logic ha, hr;
        exp_q.push_back(x);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            ha = s_axi_arready;
            hr = s_axi_rvalid;
            @(posedge sys_clk);
            if (ha) s_axi_arvalid <= 1'b0;
            n++;
        end while (!hr && n < 64);
        s_axi_rready <= 1'b0;
        if (!hr) begin
            n_fail++;
            end_sim();
        end
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        pch <= slot_channel;
        pd <= slot_data;
    end

    always @(negedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            e = exp_q.pop_front();
            chk({46'h0, s_axi_bresp}, {46'h0, e[33:32]});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = exp_q.pop_front();
            chk({14'h0, s_axi_rresp, s_axi_rdata}, {14'h0, e});
        end
        if (rst_b && !busy) begin
            chk(channel_mode_field, mirror);
            chk({47'h0, downstream_data_line},
                {47'h0, pd && pch < 5'h18 && mirror[pch * 2 +: 2] != MODE_OFF});
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end

    initial begin
        rs = 32'h512B1C09;
        {n_fail, n_tests, busy, fs_go, rst_b} = '0;
        mirror = {3{MODE_RESET}};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        for (int i = 1; i < 4; i++) rd(18'h34280 + 18'(i * 4), {RESP_OKAY, 32'h0000FFFF});
        for (int i = 0; i < 3; i++) rd(18'h342A0 + 18'(i * 4), {RESP_OKAY, 32'h0});
        rd(18'h34290, {RESP_SLVERR, 32'h0});
        wr(18'h34290, 32'h1, RESP_SLVERR);
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            d = xs();
            d[15:8] = d[15:8] | 8'hAA;
            if (k % 3 == 0) d[3:0] = d[3:0] | 4'hA;
            a = 18'h34284 + 18'(k % 3 * 4);
            s_axi_wstrb <= (k % 4 == 3) ? 4'h1 : 4'hF;
            wr(a, d, RESP_OKAY);
            rd(a, {RESP_OKAY, 16'h0, mirror[k % 3 * 16 +: 16]});
            repeat (40) @(posedge sys_clk);
        end
        s_axi_wstrb <= 4'hF;
        $display("test modes done");
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3; j++) begin
                c[j] = k == 0 ? 32'hFFFFFFFF : xs() & ~(32'h1 << STATUS_RD_BIT);
                c[j] = c[j] | (32'h1 << DELAY_RES_BIT);
                wr(18'h342A0 + 18'(j * 4), c[j], RESP_OKAY);
            end
            fs_go <= 1'b1;
            @(posedge sys_clk);
            fs_go <= 1'b0;
            repeat (8) @(posedge sys_clk);
            chk(cmd_frame, {c[2][15:0], c[1][15:0], c[0][15:0]} & {3{CMD_USED_MASK}});
            fs_go <= 1'b1;
            @(posedge sys_clk);
            fs_go <= 1'b0;
            repeat (8) @(posedge sys_clk);
            chk(cmd_frame, 48'h0);
        end
        $display("test commands done");
        end_sim();
    end
endmodule
